// ### urh_pkg.sv
// urh_pkg: register codes, field positions and reset values of the root hub control block.
// assumes a 32-bit word register command interface with separate read and write codes.
`default_nettype none
package urh_pkg;
  localparam logic [7:0] URH_RD_DESC_B   = 8'h13;
  localparam logic [7:0] URH_RD_HUB      = 8'h14;
  localparam logic [7:0] URH_RD_PORT1    = 8'h15;
  localparam logic [7:0] URH_RD_PORT2    = 8'h16;
  localparam logic [7:0] URH_WR_FLAG     = 8'h80;
  localparam int         URH_NPORTS      = 2;
  // hub status word fields
  localparam int URH_HS_CLR_WAKE  = 31;
  localparam int URH_HS_OC_CHG    = 17;
  localparam int URH_HS_SET_PWR   = 16;
  localparam int URH_HS_WAKE_EN   = 15;
  localparam int URH_HS_GLOB_OC   = 1;
  localparam int URH_HS_CLR_PWR   = 0;
  // descriptor two fields
  localparam int URH_DB_MASK_LSB  = 16;
  localparam int URH_DB_FIXED_LSB = 0;
  // port status word fields
  localparam int URH_PS_RST_CHG   = 20;
  localparam int URH_PS_OC_CHG    = 19;
  localparam int URH_PS_SUS_CHG   = 18;
  localparam int URH_PS_EN_CHG    = 17;
  localparam int URH_PS_CONN_CHG  = 16;
  localparam int URH_PS_CLR_PWR   = 9;
  localparam int URH_PS_POWER     = 8;
  localparam int URH_PS_OC        = 3;
  localparam int URH_PS_ENABLED   = 1;
  localparam int URH_PS_CONNECTED = 0;
  localparam logic [31:0] URH_ZERO_WORD = 32'h0000_0000;
  localparam logic [2:0]  URH_MASK_RST  = 3'h0;
  localparam logic [2:0]  URH_FIXED_RST = 3'h0;
  typedef enum logic [1:0] {
    URH_PS_IDLE = 2'b01,
    URH_PS_HOLD = 2'b10
  } urh_pend_t;
endpackage : urh_pkg
`default_nettype wire

// ### urh_port_flags.sv
// urh_port_flags: sticky change flags of one downstream port.
// assumes event inputs are single-cycle pulses from the same clock.
`default_nettype none
module urh_port_flags
  import urh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       reset_done,
  input  wire logic       resume_done,
  input  wire logic       oc_changed,
  input  wire logic       hw_disable,
  input  wire logic       conn_event,
  input  wire logic       clr_reset,
  input  wire logic       clr_suspend,
  input  wire logic       clr_oc,
  input  wire logic       clr_enable,
  input  wire logic       clr_connect,
  input  wire logic       per_port_oc,
  output logic [4:0]      flags
);
  logic [4:0] flags_reg;
  logic [4:0] flags_next;

  always_comb begin
    flags_next = flags_reg;
    // set wins over a same-cycle write-one clear
    if (clr_connect) flags_next[0] = 1'b0;
    if (conn_event)  flags_next[0] = 1'b1;
    if (clr_enable)  flags_next[1] = 1'b0;
    if (hw_disable)  flags_next[1] = 1'b1;  // RL17
    if (clr_suspend) flags_next[2] = 1'b0;
    if (resume_done) flags_next[2] = 1'b1;  // RL16
    if (reset_done)  flags_next[2] = 1'b0;  // RL16
    if (clr_oc)      flags_next[3] = 1'b0;
    if (oc_changed && per_port_oc) flags_next[3] = 1'b1;  // RL15
    if (clr_reset)   flags_next[4] = 1'b0;
    if (reset_done)  flags_next[4] = 1'b1;  // RL14
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) flags_reg <= 5'h0;
    else       flags_reg <= flags_next;
  end

  assign flags = flags_reg;

  chk_reset_sets_flag: assert property (@(posedge clk) disable iff (!nrst)
    reset_done |=> flags[4] && !flags[2]) else $error("reset end did not set reset change");  // RL14
  chk_enable_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    hw_disable |=> flags[1]) else $error("hardware disable did not set enable change");  // RL17
  chk_enable_no_sw: assert property (@(posedge clk) disable iff (!nrst)
    (!hw_disable && !flags[1]) |=> !flags[1])
    else $error("enable change set without hardware event");  // RL17
  chk_resume_flag: assert property (@(posedge clk) disable iff (!nrst)
    (resume_done && !reset_done) |=> flags[2]) else $error("resume end did not set suspend change");  // RL16
  chk_oc_flag: assert property (@(posedge clk) disable iff (!nrst)
    (oc_changed && per_port_oc) |=> flags[3]) else $error("port overcurrent change lost");  // RL15
endmodule : urh_port_flags
`default_nettype wire

// ### urh_root_hub.sv
// urh_root_hub: root hub descriptor two, hub status and port change flags.
// assumes the command interface gives one-cycle read/write strobes with a code byte;
// port events arrive as one-cycle pulses; overcurrent pins are asynchronous.
// Contract
// RL1: with individual switching a set mask bit leaves only per-port power commands.
// RL2: device-fixed field has bit per port, bit 0 reserved.
// RL3: hub word: status low half, change flags high half.
// RL4: writing one at bit 31 clears remote wake enable.
// RL5: hub overcurrent change set on any global overcurrent change, write-one clears; code sets it only while per-port reporting is off.
// RL6: local power and its change bit always read zero.
// RL7: writing one at bit 16 powers on unmasked or all ports.
// RL8: writing one at bit 0 powers off unmasked or all ports.
// RL9: with wake enabled, connect change while suspended gives resume and interrupt.
// RL10: writing one at bit 15 sets remote wake enable, read back there.
// RL11: global overcurrent shown only under collective reporting, else zero.
// RL12: one port word per port at codes 15H/95H and 16H/96H.
// RL13: port writes during a transaction wait until it completes.
// RL14: port reset change set at reset end, write-one clears.
// RL15: port overcurrent change set on indicator change, per-port only, write-one clears.
// RL16: suspend change set at resume end; cleared by write-one or reset change.
// RL17: enable change set only by hardware disable, write-one clears.
// RL18: software writes zero to reserved bits.
// RL19: switch select zero ganged, one individual.
// RL20: report select set with protection present gives per-port overcurrent.
// RL21: descriptor reset values are build parameters loaded at reset.
`default_nettype none
module urh_root_hub
  import urh_pkg::*;
#(
  parameter logic [2:0] MASK_INIT  = URH_MASK_RST,
  parameter logic [2:0] FIXED_INIT = URH_FIXED_RST
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_code,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  input  wire logic        power_switch_select,
  input  wire logic        overcurrent_report_select,
  input  wire logic        no_overcurrent_protect,
  input  wire logic        global_oc_pin,
  input  wire logic [1:0]  port_oc_pin,
  input  wire logic        transaction_busy,
  input  wire logic        ctrl_suspend_state,
  input  wire logic [1:0]  connect_status,
  input  wire logic [1:0]  conn_event,
  input  wire logic [1:0]  reset_done,
  input  wire logic [1:0]  resume_done,
  input  wire logic [1:0]  hw_disable,
  input  wire logic [1:0]  port_enabled,
  output logic [1:0]       port_power_on,
  output logic [1:0]       port_cmd_pulse,
  output logic [31:0]      port_cmd_bits,
  output logic             ctrl_resume_state,
  output logic             resume_irq
);
  logic [2:0]  port_power_mask_reg, port_power_mask_next;
  logic [2:0]  device_fixed_bits_reg, device_fixed_bits_next;
  logic        remote_wake_enable_reg, remote_wake_enable_next;
  logic        overcurrent_change_reg, overcurrent_change_next;
  logic [1:0]  power_reg, power_next;
  logic        resume_reg, resume_next;
  logic        irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0]  oc_s1_reg, oc_s2_reg, oc_s3_reg;
  logic [1:0]  poc_s1_reg, poc_s2_reg, poc_s3_reg;
  urh_pend_t   pend_reg [URH_NPORTS];
  urh_pend_t   pend_next [URH_NPORTS];
  logic [31:0] pdata_reg [URH_NPORTS];
  logic [31:0] pdata_next [URH_NPORTS];
  logic [1:0]  apply;
  logic [4:0]  flags [URH_NPORTS];
  logic        per_port_oc;
  logic        global_oc;
  logic        hub_wr;
  logic [1:0]  ganged_port;

  // pins cross in via two flops; third stage only for change detect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_s1_reg  <= 3'h0;
      oc_s2_reg  <= 3'h0;
      oc_s3_reg  <= 3'h0;
      poc_s1_reg <= 2'h0;
      poc_s2_reg <= 2'h0;
      poc_s3_reg <= 2'h0;
    end else begin
      oc_s1_reg  <= {2'h0, global_oc_pin};
      oc_s2_reg  <= oc_s1_reg;
      oc_s3_reg  <= oc_s2_reg;
      poc_s1_reg <= port_oc_pin;
      poc_s2_reg <= poc_s1_reg;
      poc_s3_reg <= poc_s2_reg;
    end
  end

  assign per_port_oc = overcurrent_report_select && !no_overcurrent_protect;  // RL20
  assign global_oc   = oc_s2_reg[0] && !per_port_oc && !no_overcurrent_protect;  // RL11
  assign hub_wr      = reg_wr && (reg_code == (URH_RD_HUB | URH_WR_FLAG));

  always_comb begin
    for (int i = 0; i < URH_NPORTS; i++) begin
      // ganged mode ignores the mask
      ganged_port[i] = !power_switch_select || !port_power_mask_reg[i+1];  // RL1 RL19
    end
  end

  // port writes wait for a transaction to finish
  always_comb begin
    for (int i = 0; i < URH_NPORTS; i++) begin
      pend_next[i]  = pend_reg[i];
      pdata_next[i] = pdata_reg[i];
      apply[i]      = 1'b0;
      case (pend_reg[i])
        URH_PS_IDLE: begin
          // capture first, apply from the held word so the new bits act, not the old
          if (reg_wr && reg_code == ((URH_RD_PORT1 + 8'(i)) | URH_WR_FLAG)) begin  // RL12
            pdata_next[i] = reg_wdata;
            pend_next[i]  = URH_PS_HOLD;  // RL13
          end
        end
        URH_PS_HOLD: begin
          if (!transaction_busy) begin  // RL13
            apply[i]     = 1'b1;
            pend_next[i] = URH_PS_IDLE;
          end
          // a later write while held replaces the held word
          if (reg_wr && reg_code == ((URH_RD_PORT1 + 8'(i)) | URH_WR_FLAG)) begin  // RL12
            pdata_next[i] = reg_wdata;
            pend_next[i]  = URH_PS_HOLD;
          end
        end
        default: pend_next[i] = URH_PS_IDLE;
      endcase
    end
  end

  always_comb begin
    port_power_mask_next    = port_power_mask_reg;
    device_fixed_bits_next  = device_fixed_bits_reg;
    remote_wake_enable_next = remote_wake_enable_reg;
    overcurrent_change_next = overcurrent_change_reg;
    power_next              = power_reg;
    if (reg_wr && reg_code == (URH_RD_DESC_B | URH_WR_FLAG)) begin
      port_power_mask_next   = reg_wdata[URH_DB_MASK_LSB +: 3] & 3'h6;  // RL1
      device_fixed_bits_next = reg_wdata[URH_DB_FIXED_LSB +: 3] & 3'h6;  // RL2
    end
    if (hub_wr && reg_wdata[URH_HS_WAKE_EN])  remote_wake_enable_next = 1'b1;  // RL10
    if (hub_wr && reg_wdata[URH_HS_CLR_WAKE]) remote_wake_enable_next = 1'b0;  // RL4
    if (hub_wr && reg_wdata[URH_HS_OC_CHG])   overcurrent_change_next = 1'b0;
    if (oc_s2_reg[0] != oc_s3_reg[0] && !per_port_oc) overcurrent_change_next = 1'b1;  // RL5
    for (int i = 0; i < URH_NPORTS; i++) begin
      if (hub_wr && reg_wdata[URH_HS_SET_PWR] && ganged_port[i]) power_next[i] = 1'b1;  // RL7
      if (hub_wr && reg_wdata[URH_HS_CLR_PWR] && ganged_port[i]) power_next[i] = 1'b0;  // RL8
      if (apply[i] && !ganged_port[i] && pdata_reg[i][URH_PS_POWER]) power_next[i] = 1'b1;  // RL1
      if (apply[i] && !ganged_port[i] && pdata_reg[i][URH_PS_CLR_PWR]) power_next[i] = 1'b0;  // RL1
      if (per_port_oc && poc_s2_reg[i]) power_next[i] = 1'b0;
    end
  end

  // resume on connect change while suspended
  always_comb begin
    resume_next = 1'b0;
    irq_next    = 1'b0;
    if (remote_wake_enable_reg && ctrl_suspend_state && (|conn_event)) begin  // RL9
      resume_next = 1'b1;
      irq_next    = 1'b1;
    end
  end

  always_comb begin
    rdata_next = URH_ZERO_WORD;
    if (reg_rd) begin
      case (reg_code)
        URH_RD_DESC_B: begin
          rdata_next[URH_DB_MASK_LSB +: 3]  = port_power_mask_reg;
          rdata_next[URH_DB_FIXED_LSB +: 3] = device_fixed_bits_reg;  // RL2
        end
        URH_RD_HUB: begin
          // local power bits 16 and 0 stay zero
          rdata_next[URH_HS_OC_CHG]  = overcurrent_change_reg;  // RL3 RL6
          rdata_next[URH_HS_WAKE_EN] = remote_wake_enable_reg;  // RL10
          rdata_next[URH_HS_GLOB_OC] = global_oc;  // RL11
        end
        URH_RD_PORT1, URH_RD_PORT2: begin
          for (int i = 0; i < URH_NPORTS; i++) begin
            if (reg_code == URH_RD_PORT1 + 8'(i)) begin  // RL12
              rdata_next[URH_PS_CONN_CHG +: 5] = flags[i];
              rdata_next[URH_PS_POWER]   = power_reg[i];
              rdata_next[URH_PS_OC]      = per_port_oc && poc_s2_reg[i];
              rdata_next[URH_PS_ENABLED] = port_enabled[i];
              rdata_next[URH_PS_CONNECTED] = connect_status[i] || device_fixed_bits_reg[i+1];  // RL2
            end
          end
        end
        default: rdata_next = URH_ZERO_WORD;
      endcase
    end else begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_power_mask_reg    <= MASK_INIT;  // RL21
      device_fixed_bits_reg  <= FIXED_INIT;  // RL21
      remote_wake_enable_reg <= 1'b0;
      overcurrent_change_reg <= 1'b0;
      power_reg              <= 2'h0;
      resume_reg             <= 1'b0;
      irq_reg                <= 1'b0;
      rdata_reg              <= URH_ZERO_WORD;
      for (int i = 0; i < URH_NPORTS; i++) begin
        pend_reg[i]  <= URH_PS_IDLE;
        pdata_reg[i] <= URH_ZERO_WORD;
      end
    end else begin
      port_power_mask_reg    <= port_power_mask_next;
      device_fixed_bits_reg  <= device_fixed_bits_next;
      remote_wake_enable_reg <= remote_wake_enable_next;
      overcurrent_change_reg <= overcurrent_change_next;
      power_reg              <= power_next;
      resume_reg             <= resume_next;
      irq_reg                <= irq_next;
      rdata_reg              <= rdata_next;
      for (int i = 0; i < URH_NPORTS; i++) begin
        pend_reg[i]  <= pend_next[i];
        pdata_reg[i] <= pdata_next[i];
      end
    end
  end

  for (genvar g = 0; g < URH_NPORTS; g++) begin : g_port
    urh_port_flags u_flags (
      .clk         (clk),
      .nrst        (nrst),
      .reset_done  (reset_done[g]),
      .resume_done (resume_done[g]),
      .oc_changed  (poc_s2_reg[g] != poc_s3_reg[g]),
      .hw_disable  (hw_disable[g]),
      .conn_event  (conn_event[g]),
      .clr_reset   (apply[g] && pdata_reg[g][URH_PS_RST_CHG]),
      .clr_suspend (apply[g] && pdata_reg[g][URH_PS_SUS_CHG]),
      .clr_oc      (apply[g] && pdata_reg[g][URH_PS_OC_CHG]),
      .clr_enable  (apply[g] && pdata_reg[g][URH_PS_EN_CHG]),
      .clr_connect (apply[g] && pdata_reg[g][URH_PS_CONN_CHG]),
      .per_port_oc (per_port_oc),
      .flags       (flags[g])
    );
  end

  assign reg_rdata         = rdata_reg;
  assign port_power_on     = power_reg;
  assign port_cmd_pulse    = apply;
  assign port_cmd_bits     = pdata_reg[0] | pdata_reg[1];
  assign ctrl_resume_state = resume_reg;
  assign resume_irq        = irq_reg;

  sequence s_port_write_busy;
    reg_wr && reg_code == (URH_RD_PORT1 | URH_WR_FLAG) && transaction_busy;
  endsequence
  chk_defer_port_write: assert property (@(posedge clk) disable iff (!nrst)
    s_port_write_busy |-> !apply[0] ##1 (pend_reg[0] == URH_PS_HOLD))
    else $error("port write not held during transaction");  // RL13
  chk_no_apply_busy: assert property (@(posedge clk) disable iff (!nrst)
    transaction_busy |-> apply == 2'h0) else $error("port write applied during transaction");  // RL13
  chk_wake_clear: assert property (@(posedge clk) disable iff (!nrst)
    (hub_wr && reg_wdata[URH_HS_CLR_WAKE]) |=> !remote_wake_enable_reg) else $error("wake enable not cleared");  // RL4
  chk_wake_set: assert property (@(posedge clk) disable iff (!nrst)
    (hub_wr && reg_wdata[URH_HS_WAKE_EN] && !reg_wdata[URH_HS_CLR_WAKE]) |=> remote_wake_enable_reg)
    else $error("wake enable not set");  // RL10
  chk_oc_change: assert property (@(posedge clk) disable iff (!nrst)
    (oc_s2_reg[0] != oc_s3_reg[0] && !per_port_oc) |=> overcurrent_change_reg)
    else $error("hub overcurrent change lost");  // RL5
  chk_global_power_on: assert property (@(posedge clk) disable iff (!nrst)
    (hub_wr && reg_wdata[URH_HS_SET_PWR] && !reg_wdata[URH_HS_CLR_PWR] && !power_switch_select && !per_port_oc)
    |=> power_reg == 2'h3) else $error("ganged power on failed");  // RL7
  chk_global_power_off: assert property (@(posedge clk) disable iff (!nrst)
    (hub_wr && reg_wdata[URH_HS_CLR_PWR] && !power_switch_select) |=> power_reg == 2'h0)
    else $error("ganged power off failed");  // RL8
  chk_masked_port_held: assert property (@(posedge clk) disable iff (!nrst)
    (hub_wr && power_switch_select && port_power_mask_reg[1] && !apply[0] && !per_port_oc)
    |=> power_reg[0] == $past(power_reg[0])) else $error("masked port took global command");  // RL1
  chk_resume_event: assert property (@(posedge clk) disable iff (!nrst)
    (remote_wake_enable_reg && ctrl_suspend_state && conn_event[0]) |=> ctrl_resume_state && resume_irq)
    else $error("resume not raised");  // RL9
endmodule : urh_root_hub
`default_nettype wire

// ### urh_pkg_unused_check.sv
`default_nettype none
`default_nettype wire

// ### urh_host_model.sv
// urh_host_model: host processor side of the register command interface.
// assumes the block takes a strobe on the rising edge where it is high.
`default_nettype none
module urh_host_model
  import urh_pkg::*;
(
  input  wire logic        clk,
  output logic [7:0]       reg_code,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [31:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_code  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // idle bus shows inverted values so stale data never passes as valid
  task automatic release_bus;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_code  = ~reg_code;
    reg_wdata = ~reg_wdata;
  endtask : release_bus
  task automatic write_word(input logic [7:0] code, input logic [31:0] data);
    @(negedge clk);
    reg_code  = code | URH_WR_FLAG;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge clk);
    release_bus();
  endtask : write_word
  // one idle edge after the answer so read data is never overwritten early
  task automatic read_word(input logic [7:0] code);
    @(negedge clk);
    reg_code = code;
    reg_rd   = 1'b1;
    @(posedge clk);
    release_bus();
    @(negedge clk);
  endtask : read_word
endmodule : urh_host_model
`default_nettype wire

// ### urh_root_hub_tb.sv
// urh_root_hub_tb: self-checking bench of the root hub control block.
// assumes the host model drives the command bus; port events come from here.
`default_nettype none
module urh_root_hub_tb
  import urh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] MASK_P  = 3'h4;
  localparam logic [2:0] FIXED_P = 3'h2;
  localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
  localparam logic [31:0] PMASK = 32'h001E_0000;
  logic clk, nrst, reg_wr, reg_rd, pss, ors, nop, goc, busy, susp;
  logic ctrl_resume_state, resume_irq;
  logic [7:0] reg_code;
  logic [31:0] reg_wdata, reg_rdata, port_cmd_bits;
  logic [1:0] poc, cstat, conn_event, reset_done, resume_done, hw_disable, pen;
  logic [1:0] port_power_on, port_cmd_pulse;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic taken = 1'b0;
  logic taken_d = 1'b0;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h789d;
  urh_host_model i_host (.clk(clk), .reg_code(reg_code), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  urh_root_hub #(.MASK_INIT(MASK_P), .FIXED_INIT(FIXED_P)) i_dut (.clk(clk), .nrst(nrst),
    .reg_code(reg_code), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_switch_select(pss), .overcurrent_report_select(ors),
    .no_overcurrent_protect(nop), .global_oc_pin(goc), .port_oc_pin(poc),
    .transaction_busy(busy), .ctrl_suspend_state(susp), .connect_status(cstat),
    .conn_event(conn_event), .reset_done(reset_done), .resume_done(resume_done),
    .hw_disable(hw_disable), .port_enabled(pen), .port_power_on(port_power_on),
    .port_cmd_pulse(port_cmd_pulse), .port_cmd_bits(port_cmd_bits),
    .ctrl_resume_state(ctrl_resume_state), .resume_irq(resume_irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd(input logic [7:0] code, input logic [31:0] exp, input logic [31:0] msk);
    exp_q.push_back(exp & msk);
    msk_q.push_back(msk);
    i_host.read_word(code);
  endtask : rd
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    i_host.write_word(code, data);
  endtask : wr
  // a few cycles covers the overcurrent synchronisers and write latency
  task automatic settle;
    repeat (6) @(negedge clk);
    cstat = 2'($random(seed));
  endtask : settle
  task automatic pulse(ref logic [1:0] sig, input logic [1:0] v);
    @(negedge clk);
    sig = v;
    @(negedge clk);
    sig = 2'b00;
  endtask : pulse
  task automatic chk_pwr(input logic [1:0] e);
    settle();
    check("port_power_on", {30'h0, e}, {30'h0, port_power_on});
  endtask : chk_pwr
  task automatic watch_resume(input logic want);
    logic [1:0] seen;
    seen = 2'b00;
    @(negedge clk);
    conn_event = 2'b01;
    repeat (10) begin
      @(negedge clk);
      conn_event = 2'b00;
      seen = seen | {ctrl_resume_state === 1'b1, resume_irq === 1'b1};
    end
    check("resume pulses", {30'h0, want, want}, {30'h0, seen});
  endtask : watch_resume
  always @(posedge clk) begin
    taken_d <= taken;
    taken   <= (reg_rd === 1'b1);
  end
  always @(negedge clk) begin
    if (taken_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("wrong value read queue expected note seen none");
      end else begin
        check("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
      end
    end
  end
  initial begin
    #400us;
    errors++;
    $display("wrong value run time expected end seen hang");
    complete_run();
  end
  initial begin
    {nrst, pss, ors, nop, goc, busy, susp} = 7'h00;
    {poc, cstat, conn_event, reset_done, resume_done, hw_disable, pen} = 14'h0000;
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    rd(8'h13, {13'h0000, MASK_P, 13'h0000, FIXED_P}, ALL);
    rd(8'h14, 32'h0000_0000, ALL);
    rd(8'h15, 32'h0000_0000, 32'hFFFF_0000);
    rd(8'h16, 32'h0000_0000, 32'hFFFF_0000);
    rd(8'h17, 32'h0000_0000, ALL);
    wr(8'h13, 32'h0006_0004);
    rd(8'h13, 32'h0006_0004, ALL);
    $display("test reset and descriptor done");
    wr(8'h14, 32'h0001_0000);
    chk_pwr(2'b11);
    wr(8'h14, 32'h0000_0001);
    chk_pwr(2'b00);
    pss = 1'b1;
    wr(8'h13, 32'h0002_0000);
    wr(8'h14, 32'h0001_0000);
    chk_pwr(2'b10);
    wr(8'h15, 32'h0000_0100);
    chk_pwr(2'b11);
    wr(8'h14, 32'h0000_0001);
    chk_pwr(2'b01);
    $display("test power switching done");
    wr(8'h14, 32'h0000_8000);
    wr(8'h14, 32'h0000_0000);
    rd(8'h14, 32'h0000_8000, ALL);
    susp = 1'b1;
    watch_resume(1'b1);
    wr(8'h14, 32'h8000_0000);
    rd(8'h14, 32'h0000_0000, ALL);
    watch_resume(1'b0);
    susp = 1'b0;
    $display("test remote wake done");
    goc = 1'b1;
    settle();
    rd(8'h14, 32'h0002_0002, 32'h0003_0003);
    wr(8'h14, 32'h0002_0000);
    rd(8'h14, 32'h0000_0002, 32'h0003_0003);
    goc = 1'b0;
    settle();
    rd(8'h14, 32'h0002_0000, 32'h0003_0003);
    wr(8'h14, 32'h0002_0000);
    ors = 1'b1;
    goc = 1'b1;
    settle();
    rd(8'h14, 32'h0000_0000, 32'h0001_0003);
    goc = 1'b0;
    $display("test hub overcurrent done");
    pen = 2'b11;
    for (int p = 0; p < URH_NPORTS; p++) begin
      pulse(resume_done, 2'b01 << p);
      rd(8'h15 + p[7:0], 32'h0004_0000, PMASK);
      pulse(reset_done, 2'b01 << p);
      rd(8'h15 + p[7:0], 32'h0010_0000, PMASK);
      wr(8'h15 + p[7:0], 32'h0000_0001);
      rd(8'h15 + p[7:0], 32'h0010_0000, PMASK);
      pulse(hw_disable, 2'b01 << p);
      poc[p] = 1'b1;
      settle();
      rd(8'h15 + p[7:0], 32'h001A_0002 | 32'(cstat[p]), PMASK | 32'h0000_0003);
      poc[p] = 1'b0;
      settle();
      wr(8'h15 + p[7:0], 32'h001A_0000);
      settle();
      rd(8'h15 + p[7:0], 32'h0000_0000, PMASK);
    end
    $display("test port flags done");
    pulse(reset_done, 2'b01);
    busy = 1'b1;
    wr(8'h15, 32'h0010_0000);
    settle();
    rd(8'h15, 32'h0010_0000, PMASK);
    check("port_cmd_pulse", 32'h0000_0000, {30'h0, port_cmd_pulse});
    check("port_cmd_bits", 32'h0010_0000, port_cmd_bits & 32'h0010_0000);
    busy = 1'b0;
    settle();
    rd(8'h15, 32'h0000_0000, PMASK);
    $display("test deferred write done");
    repeat (4) @(negedge clk);
    complete_run();
  end
endmodule : urh_root_hub_tb
`default_nettype wire
